// >>> bst_dev.sv
// Device end: TAP controller, instruction, bypass, identity and boundary registers
`timescale 1ns/100ps
`include "bst_defs.svh"
module bst_dev #(
	// Identity field values are arbitrary
	parameter logic [3:0]  ID_VERSION = 4'h1,
	parameter logic [15:0] ID_PART    = 16'h0c3a,
	parameter logic [10:0] ID_MANUF   = 11'h07b
) (
	input  wire logic                    mclk,
	input  wire logic                    rst,
	bst_if.dev                           jtag,
	input  wire logic [`BST_BSR_LEN-1:0] core_out,
	input  wire logic [`BST_BSR_LEN-1:0] core_oe,
	input  wire logic [`BST_BSR_LEN-1:0] pin_in,
	output logic      [`BST_BSR_LEN-1:0] pin_out,
	output logic      [`BST_BSR_LEN-1:0] pin_oe
);

	// ****************************************************************
	// State and decode
	// ****************************************************************
	bst_pkg::bst_dev_st_t q_ff;
	bst_pkg::bst_dev_st_t nxt_q;

	logic                 rise;
	logic                 fall;
	logic                 tms;
	logic                 tdi;
	logic                 sel_bsr;
	logic                 sel_id;
	logic                 drive_bsr;
	logic                 float_all;
	logic [`BST_ID_W-1:0] id_word;

	assign rise = q_ff.tck_s[1] & ~q_ff.tck_q;
	assign fall = ~q_ff.tck_s[1] & q_ff.tck_q;
	assign tms  = q_ff.tms_s[1];
	assign tdi  = q_ff.tdi_s[1];

	// Sample and extest reach the boundary register
	assign sel_bsr = (q_ff.ir_par == `BST_IR_SAMPLE) ||
	                 (q_ff.ir_par == `BST_IR_EXTEST);
	assign sel_id  = (q_ff.ir_par == `BST_IR_IDCODE);
	// Extest and clamp take the pins from the boundary parallel stage
	assign drive_bsr = (q_ff.ir_par == `BST_IR_EXTEST) ||
	                   (q_ff.ir_par == `BST_IR_CLAMP);
	assign float_all = (q_ff.ir_par == `BST_IR_HIGHZ);

	assign id_word = {ID_VERSION, ID_PART, ID_MANUF, `BST_ID_MARK};

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		nxt_q = q_ff;

		// Two-stage synchronisers for every pin from the tester or the board
		nxt_q.tck_s  = {q_ff.tck_s[0], jtag.test_clock};
		nxt_q.tms_s  = {q_ff.tms_s[0], jtag.test_mode_select};
		nxt_q.tdi_s  = {q_ff.tdi_s[0], jtag.test_data_in};
		nxt_q.trst_s = {q_ff.trst_s[0], jtag.test_reset_n};
		nxt_q.pin_s0 = pin_in;
		nxt_q.pin_s1 = q_ff.pin_s0;
		nxt_q.tck_q  = q_ff.tck_s[1];

		// Rising test clock: register actions of the current state
		if (rise) begin
			case (q_ff.tap)
				bst_pkg::TAP_CAP_IR: begin
					nxt_q.ir_sh = `BST_IR_CAPTURE;
				end
				bst_pkg::TAP_SH_IR: begin
					nxt_q.ir_sh = {tdi, q_ff.ir_sh[`BST_IR_W-1:1]};
				end
				bst_pkg::TAP_CAP_DR: begin
					if (sel_bsr) begin
						nxt_q.bsr_sh = q_ff.pin_s1;
					end else if (sel_id) begin
						nxt_q.id_sh = id_word;
					end else begin
						nxt_q.byp = 1'b0;
					end
				end
				bst_pkg::TAP_SH_DR: begin
					if (sel_bsr) begin
						nxt_q.bsr_sh = {tdi, q_ff.bsr_sh[`BST_BSR_LEN-1:1]};
					end else if (sel_id) begin
						nxt_q.id_sh = {tdi, q_ff.id_sh[`BST_ID_W-1:1]};
					end else begin
						nxt_q.byp = tdi;
					end
				end
				default: begin
				end
			endcase

			// Controller moves on the mode select level at each rising edge
			case (q_ff.tap)
				bst_pkg::TAP_RESET: begin
					nxt_q.tap = tms ? bst_pkg::TAP_RESET : bst_pkg::TAP_IDLE;
				end
				bst_pkg::TAP_IDLE: begin
					nxt_q.tap = tms ? bst_pkg::TAP_SEL_DR : bst_pkg::TAP_IDLE;
				end
				bst_pkg::TAP_SEL_DR: begin
					nxt_q.tap = tms ? bst_pkg::TAP_SEL_IR : bst_pkg::TAP_CAP_DR;
				end
				bst_pkg::TAP_CAP_DR: begin
					nxt_q.tap = tms ? bst_pkg::TAP_EX1_DR : bst_pkg::TAP_SH_DR;
				end
				bst_pkg::TAP_SH_DR: begin
					nxt_q.tap = tms ? bst_pkg::TAP_EX1_DR : bst_pkg::TAP_SH_DR;
				end
				bst_pkg::TAP_EX1_DR: begin
					nxt_q.tap = tms ? bst_pkg::TAP_UPD_DR : bst_pkg::TAP_PA_DR;
				end
				bst_pkg::TAP_PA_DR: begin
					nxt_q.tap = tms ? bst_pkg::TAP_EX2_DR : bst_pkg::TAP_PA_DR;
				end
				bst_pkg::TAP_EX2_DR: begin
					nxt_q.tap = tms ? bst_pkg::TAP_UPD_DR : bst_pkg::TAP_SH_DR;
				end
				bst_pkg::TAP_UPD_DR: begin
					nxt_q.tap = tms ? bst_pkg::TAP_SEL_DR : bst_pkg::TAP_IDLE;
				end
				bst_pkg::TAP_SEL_IR: begin
					nxt_q.tap = tms ? bst_pkg::TAP_RESET : bst_pkg::TAP_CAP_IR;
				end
				bst_pkg::TAP_CAP_IR: begin
					nxt_q.tap = tms ? bst_pkg::TAP_EX1_IR : bst_pkg::TAP_SH_IR;
				end
				bst_pkg::TAP_SH_IR: begin
					nxt_q.tap = tms ? bst_pkg::TAP_EX1_IR : bst_pkg::TAP_SH_IR;
				end
				bst_pkg::TAP_EX1_IR: begin
					nxt_q.tap = tms ? bst_pkg::TAP_UPD_IR : bst_pkg::TAP_PA_IR;
				end
				bst_pkg::TAP_PA_IR: begin
					nxt_q.tap = tms ? bst_pkg::TAP_EX2_IR : bst_pkg::TAP_PA_IR;
				end
				bst_pkg::TAP_EX2_IR: begin
					nxt_q.tap = tms ? bst_pkg::TAP_UPD_IR : bst_pkg::TAP_SH_IR;
				end
				bst_pkg::TAP_UPD_IR: begin
					nxt_q.tap = tms ? bst_pkg::TAP_SEL_DR : bst_pkg::TAP_IDLE;
				end
				default: begin
					nxt_q.tap = bst_pkg::TAP_RESET;
				end
			endcase
		end

		// Falling test clock: parallel stages and data out
		if (fall) begin
			if (q_ff.tap == bst_pkg::TAP_UPD_IR) begin
				nxt_q.ir_par = q_ff.ir_sh;
			end
			if (q_ff.tap == bst_pkg::TAP_UPD_DR) begin
				if (sel_bsr) begin
					nxt_q.bsr_par = q_ff.bsr_sh;
				end
				if (sel_id) begin
					nxt_q.id_par = q_ff.id_sh;
				end
			end
			if (q_ff.tap == bst_pkg::TAP_SH_IR) begin
				nxt_q.tdo    = q_ff.ir_sh[0];
				nxt_q.tdo_oe = 1'b1;
			end else if (q_ff.tap == bst_pkg::TAP_SH_DR) begin
				nxt_q.tdo_oe = 1'b1;
				if (sel_bsr) begin
					nxt_q.tdo = q_ff.bsr_sh[0];
				end else if (sel_id) begin
					nxt_q.tdo = q_ff.id_sh[0];
				end else begin
					nxt_q.tdo = q_ff.byp;
				end
			end else begin
				nxt_q.tdo_oe = 1'b0;
			end
		end

		// Identity instruction is held throughout Test-Logic-Reset
		if (q_ff.tap == bst_pkg::TAP_RESET) begin
			nxt_q.ir_par = `BST_IR_IDCODE;
		end

		// Test reset low overrides the controller state, instruction and data out enable set above
		if (!q_ff.trst_s[1]) begin
			nxt_q.tap    = bst_pkg::TAP_RESET;
			nxt_q.ir_par = `BST_IR_IDCODE;
			nxt_q.tdo_oe = 1'b0;
		end

		// ****************************************************************
		// Pin drive: in extest and clamp, cell 67 of the boundary parallel stage sets the output enable of cell 66
		// ****************************************************************
		if (float_all) begin
			nxt_q.pin_out = q_ff.bsr_par;
			nxt_q.pin_oe  = '0;
		end else if (drive_bsr) begin
			nxt_q.pin_out = q_ff.bsr_par;
			nxt_q.pin_oe  = '1;
			nxt_q.pin_oe[`BST_CELL_SHARED] = q_ff.bsr_par[`BST_CELL_SHARED_DIR];
		end else begin
			nxt_q.pin_out = core_out;
			nxt_q.pin_oe  = core_oe;
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			q_ff        <= '0;
			q_ff.tap    <= bst_pkg::TAP_RESET;
			q_ff.ir_par <= `BST_IR_IDCODE;
			// Test reset idles high, so no false test reset follows rst
			q_ff.trst_s <= 2'h3;
		end else begin
			q_ff <= nxt_q;
		end
	end

	assign jtag.test_data_out    = q_ff.tdo;
	assign jtag.test_data_out_oe = q_ff.tdo_oe;
	assign pin_out               = q_ff.pin_out;
	assign pin_oe                = q_ff.pin_oe;

endmodule

// >>> bst_defs.svh
// Constants for the boundary scan test access port and its tester end
// How it works
// - Update-IR falling edge latches new instruction
// - Update-IR goes to Run-Test-Idle or Select-DR
// - Shift-IR moves instruction bits toward data out
// - Exit1/Exit2-IR with select high reach Update-IR
// - Codes 010 sample, 111 bypass, 000 extest
// - Codes 011 clamp, 100 highz, 001 idcode
// - Sample captures pins, shifts without disturbing function
// - Extest drives outputs from boundary parallel stage
// - Bypass uses one stage between data pins
// - Idcode loads identity at Capture-DR, shifts out
// - Test-Logic-Reset forces identity instruction
// - Identity word: lsb one, maker, part, version
// - Highz floats all outputs, bypass in path
// - Clamp holds boundary values, bypass in path
// - Boundary register has 126 cells, two stages
// - Identity register has shift and parallel stage
// - Cell 67 sets direction of cell 66
// - Controller follows mode select at rising edges
// - Power up in Test-Logic-Reset with identity
// - Exit1-IR with select low enters Pause-IR
`ifndef BST_DEFS_SVH
`define BST_DEFS_SVH

// ****************************************************************
// Instruction register
// ****************************************************************
`define BST_IR_W            3
`define BST_IR_EXTEST       3'h0
`define BST_IR_IDCODE       3'h1
`define BST_IR_SAMPLE       3'h2
`define BST_IR_CLAMP        3'h3
`define BST_IR_HIGHZ        3'h4
`define BST_IR_BYPASS       3'h7
`define BST_IR_CAPTURE      3'h1

// ****************************************************************
// Data registers
// ****************************************************************
`define BST_BSR_LEN         126
`define BST_ID_W            32
`define BST_ID_MARK         1'h1
`define BST_CELL_SHARED     66
`define BST_CELL_SHARED_DIR 67

// ****************************************************************
// Tester timing and scan sequences
// ****************************************************************
`define BST_MCLK_NS         10
`define BST_TCK_HALF_NS     80
`define BST_TCK_HALF_CYC    (`BST_TCK_HALF_NS / `BST_MCLK_NS)
`define BST_DIV_W           8
`define BST_SCAN_MAX        128
`define BST_LEN_W           8
`define BST_PRE_IR          5'h03
`define BST_PRE_IR_N        3'h4
`define BST_PRE_DR          5'h01
`define BST_PRE_DR_N        3'h3
`define BST_PRE_RST         5'h1f
`define BST_PRE_RST_N       3'h5
`define BST_POST_SCAN       2'h2
`define BST_POST_RST        2'h1

`endif

// >>> bst_pkg.sv
// Types shared by both ends of the boundary scan port
package bst_pkg;
`include "bst_defs.svh"

	typedef enum logic [3:0] {
		TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
		TAP_PA_DR, TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR,
		TAP_EX1_IR, TAP_PA_IR, TAP_EX2_IR, TAP_UPD_IR
	} bst_tap_t;

	typedef enum logic [1:0] {OP_RESET, OP_IR, OP_DR} bst_op_t;

	typedef enum logic [2:0] {HP_IDLE, HP_PRE, HP_SHIFT, HP_POST, HP_FIN} bst_hph_t;

	typedef struct packed {
		logic [1:0]              tck_s;
		logic [1:0]              tms_s;
		logic [1:0]              tdi_s;
		logic [1:0]              trst_s;
		logic                    tck_q;
		logic [`BST_BSR_LEN-1:0] pin_s0;
		logic [`BST_BSR_LEN-1:0] pin_s1;
		bst_tap_t                tap;
		logic [`BST_IR_W-1:0]    ir_sh;
		logic [`BST_IR_W-1:0]    ir_par;
		logic                    byp;
		logic [`BST_ID_W-1:0]    id_sh;
		logic [`BST_ID_W-1:0]    id_par;
		logic [`BST_BSR_LEN-1:0] bsr_sh;
		logic [`BST_BSR_LEN-1:0] bsr_par;
		logic                    tdo;
		logic                    tdo_oe;
		logic [`BST_BSR_LEN-1:0] pin_out;
		logic [`BST_BSR_LEN-1:0] pin_oe;
	} bst_dev_st_t;

	typedef struct packed {
		logic [`BST_DIV_W-1:0]    div;
		logic                     tck;
		logic                     tms;
		logic                     tdi;
		logic                     trst_n;
		logic [1:0]               tdo_s;
		bst_hph_t                 phase;
		bst_op_t                  op;
		logic [4:0]               pre_tms;
		logic [2:0]               pre_cnt;
		logic [1:0]               post_cnt;
		logic [`BST_LEN_W-1:0]    len;
		logic [`BST_LEN_W-1:0]    bit_idx;
		logic [`BST_LEN_W-1:0]    samp;
		logic                     act;
		logic [`BST_SCAN_MAX-1:0] data;
		logic [`BST_SCAN_MAX-1:0] res;
		logic                     ready;
		logic                     rsp_valid;
	} bst_host_st_t;
endpackage

// >>> bst_if.sv
// Test access port wires between the tester and the device
`timescale 1ns/100ps
interface bst_if;
	logic test_clock;
	logic test_mode_select;
	logic test_data_in;
	logic test_reset_n;
	logic test_data_out;
	logic test_data_out_oe;
	logic test_data_out_line;

	// Undriven data out line is pulled high
	assign test_data_out_line = test_data_out_oe ? test_data_out : 1'b1;

	modport dev (
		input  test_clock,
		input  test_mode_select,
		input  test_data_in,
		input  test_reset_n,
		output test_data_out,
		output test_data_out_oe
	);

	modport host (
		output test_clock,
		output test_mode_select,
		output test_data_in,
		output test_reset_n,
		input  test_data_out_line
	);
endinterface

// >>> bst_host.sv
// Tester end: makes the test clock and runs reset, instruction and data scans
`timescale 1ns/100ps
`include "bst_defs.svh"
module bst_host (
	input  wire logic                     mclk,
	input  wire logic                     rst,
	bst_if.host                           jtag,
	input  wire logic                     cmd_valid,
	input  wire bst_pkg::bst_op_t         cmd_op,
	input  wire logic [`BST_LEN_W-1:0]    cmd_len,
	input  wire logic [`BST_SCAN_MAX-1:0] cmd_data,
	output logic                          cmd_ready,
	output logic                          rsp_valid,
	output logic [`BST_SCAN_MAX-1:0]      rsp_data
);

	localparam logic [`BST_DIV_W-1:0] HALF_M1 = `BST_DIV_W'(`BST_TCK_HALF_CYC - 1);

	bst_pkg::bst_host_st_t q_ff;
	bst_pkg::bst_host_st_t nxt_q;

	logic tick;

	assign tick = (q_ff.div == HALF_M1);

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	always_comb begin
		nxt_q           = q_ff;
		nxt_q.tdo_s     = {q_ff.tdo_s[0], jtag.test_data_out_line};
		nxt_q.rsp_valid = 1'b0;

		// Free-running test clock from the system clock
		if (tick) begin
			nxt_q.div = '0;
			nxt_q.tck = ~q_ff.tck;
		end else begin
			nxt_q.div = q_ff.div + `BST_DIV_W'(1);
		end

		if (q_ff.phase == bst_pkg::HP_IDLE && cmd_valid && q_ff.ready) begin
			nxt_q.ready   = 1'b0;
			nxt_q.phase   = bst_pkg::HP_PRE;
			nxt_q.op      = cmd_op;
			nxt_q.len     = cmd_len;
			nxt_q.data    = cmd_data;
			nxt_q.res     = '0;
			nxt_q.bit_idx = '0;
			case (cmd_op)
				bst_pkg::OP_IR: begin
					nxt_q.pre_tms  = `BST_PRE_IR;
					nxt_q.pre_cnt  = `BST_PRE_IR_N;
					nxt_q.post_cnt = `BST_POST_SCAN;
				end
				bst_pkg::OP_DR: begin
					nxt_q.pre_tms  = `BST_PRE_DR;
					nxt_q.pre_cnt  = `BST_PRE_DR_N;
					nxt_q.post_cnt = `BST_POST_SCAN;
				end
				default: begin
					nxt_q.pre_tms  = `BST_PRE_RST;
					nxt_q.pre_cnt  = `BST_PRE_RST_N;
					nxt_q.post_cnt = `BST_POST_RST;
					nxt_q.trst_n   = 1'b0;
				end
			endcase
		end

		// Falling test clock: present mode select and data in
		if (tick && q_ff.tck) begin
			nxt_q.act = 1'b0;
			case (q_ff.phase)
				bst_pkg::HP_PRE: begin
					nxt_q.tms     = q_ff.pre_tms[0];
					nxt_q.pre_tms = q_ff.pre_tms >> 1;
					nxt_q.pre_cnt = q_ff.pre_cnt - 3'h1;
					if (q_ff.pre_cnt == 3'h1) begin
						nxt_q.phase = (q_ff.op == bst_pkg::OP_RESET) ?
						              bst_pkg::HP_POST : bst_pkg::HP_SHIFT;
					end
				end
				bst_pkg::HP_SHIFT: begin
					// Last bit leaves the shift state toward Exit1
					nxt_q.tms     = (q_ff.bit_idx == q_ff.len - `BST_LEN_W'(1));
					nxt_q.tdi     = q_ff.data[q_ff.bit_idx[6:0]];
					nxt_q.act     = 1'b1;
					nxt_q.samp    = q_ff.bit_idx;
					nxt_q.bit_idx = q_ff.bit_idx + `BST_LEN_W'(1);
					if (q_ff.bit_idx == q_ff.len - `BST_LEN_W'(1)) begin
						nxt_q.phase = bst_pkg::HP_POST;
					end
				end
				bst_pkg::HP_POST: begin
					// Update then back to Run-Test-Idle
					nxt_q.tms      = (q_ff.post_cnt == `BST_POST_SCAN);
					nxt_q.post_cnt = q_ff.post_cnt - 2'h1;
					if (q_ff.post_cnt == 2'h1) begin
						nxt_q.phase = bst_pkg::HP_FIN;
					end
				end
				default: begin
					nxt_q.tms = 1'b0;
				end
			endcase
		end

		// Rising test clock: sample data out, finish the command
		if (tick && !q_ff.tck) begin
			if (q_ff.act) begin
				nxt_q.res[q_ff.samp[6:0]] = q_ff.tdo_s[1];
			end
			if (q_ff.phase == bst_pkg::HP_FIN) begin
				nxt_q.phase     = bst_pkg::HP_IDLE;
				nxt_q.ready     = 1'b1;
				nxt_q.rsp_valid = 1'b1;
				nxt_q.trst_n    = 1'b1;
			end
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			q_ff        <= '0;
			q_ff.trst_n <= 1'b1;
			q_ff.ready  <= 1'b1;
		end else begin
			q_ff <= nxt_q;
		end
	end

	assign jtag.test_clock       = q_ff.tck;
	assign jtag.test_mode_select = q_ff.tms;
	assign jtag.test_data_in     = q_ff.tdi;
	assign jtag.test_reset_n     = q_ff.trst_n;
	assign cmd_ready             = q_ff.ready;
	assign rsp_valid             = q_ff.rsp_valid;
	assign rsp_data              = q_ff.res;

endmodule

// >>> bst_asserts.sv
// Checker of the scan port wires with a shadow controller state
`timescale 1ns/100ps
module bst_asserts (
	input wire logic mclk,
	input wire logic rst,
	input wire logic test_clock,
	input wire logic test_mode_select,
	input wire logic test_data_in,
	input wire logic test_reset_n,
	input wire logic test_data_out,
	input wire logic test_data_out_oe,
	input wire logic test_data_out_line
);
	typedef struct packed {
		logic              tck_q;
		bst_pkg::bst_tap_t st;
		logic [2:0]        ir_sh;
		logic [2:0]        ir;
		logic              first;
		logic              tdi_q;
	} bst_chk_st_t;
	bst_chk_st_t chk_ff;
	bst_chk_st_t nxt_chk;
	logic        rise;
	logic        fall;
	logic        shift;
	logic        ir_sh_rise;
	logic        dr_sh_rise;
	logic        byp_sel;
	logic        id_sel;

	// ********
	// Shadow controller
	// ********
	function automatic bst_pkg::bst_tap_t tap_next(input bst_pkg::bst_tap_t s, input logic m);
		case (s)
			bst_pkg::TAP_RESET: tap_next = m ? bst_pkg::TAP_RESET : bst_pkg::TAP_IDLE;
			bst_pkg::TAP_SEL_DR: tap_next = m ? bst_pkg::TAP_SEL_IR : bst_pkg::TAP_CAP_DR;
			bst_pkg::TAP_CAP_DR, bst_pkg::TAP_SH_DR, bst_pkg::TAP_EX2_DR:
				tap_next = m ? bst_pkg::TAP_EX1_DR : bst_pkg::TAP_SH_DR;
			bst_pkg::TAP_EX1_DR: tap_next = m ? bst_pkg::TAP_UPD_DR : bst_pkg::TAP_PA_DR;
			bst_pkg::TAP_PA_DR: tap_next = m ? bst_pkg::TAP_EX2_DR : bst_pkg::TAP_PA_DR;
			bst_pkg::TAP_SEL_IR: tap_next = m ? bst_pkg::TAP_RESET : bst_pkg::TAP_CAP_IR;
			bst_pkg::TAP_CAP_IR, bst_pkg::TAP_SH_IR, bst_pkg::TAP_EX2_IR:
				tap_next = m ? bst_pkg::TAP_EX1_IR : bst_pkg::TAP_SH_IR;
			bst_pkg::TAP_EX1_IR: tap_next = m ? bst_pkg::TAP_UPD_IR : bst_pkg::TAP_PA_IR;
			bst_pkg::TAP_PA_IR: tap_next = m ? bst_pkg::TAP_EX2_IR : bst_pkg::TAP_PA_IR;
			default: tap_next = m ? bst_pkg::TAP_SEL_DR : bst_pkg::TAP_IDLE;
		endcase
	endfunction

	assign rise = test_clock && !chk_ff.tck_q;
	assign fall = !test_clock && chk_ff.tck_q;
	assign shift = (chk_ff.st == bst_pkg::TAP_SH_IR) || (chk_ff.st == bst_pkg::TAP_SH_DR);
	assign ir_sh_rise = rise && (chk_ff.st == bst_pkg::TAP_SH_IR);
	assign dr_sh_rise = rise && (chk_ff.st == bst_pkg::TAP_SH_DR);
	assign byp_sel    = (chk_ff.ir > 3'h2);
	assign id_sel     = (chk_ff.ir == 3'h1);

	always_comb begin
		nxt_chk = chk_ff;
		nxt_chk.tck_q = test_clock;
		if (!test_reset_n) begin
			nxt_chk.st = bst_pkg::TAP_RESET;
		end else if (rise) begin
			nxt_chk.st = tap_next(chk_ff.st, test_mode_select);
			if (chk_ff.st == bst_pkg::TAP_SH_IR) nxt_chk.ir_sh = {test_data_in, chk_ff.ir_sh[2:1]};
			if (chk_ff.st == bst_pkg::TAP_CAP_IR) nxt_chk.ir_sh = 3'h1;
			if (nxt_chk.st == bst_pkg::TAP_UPD_IR) nxt_chk.ir = chk_ff.ir_sh;
			nxt_chk.first = !test_mode_select &&
				(chk_ff.st == bst_pkg::TAP_CAP_DR || chk_ff.st == bst_pkg::TAP_CAP_IR);
			nxt_chk.tdi_q = test_data_in;
		end
		if (nxt_chk.st == bst_pkg::TAP_RESET) nxt_chk.ir = 3'h1;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) chk_ff <= '{st: bst_pkg::TAP_RESET, ir: 3'h1, default: '0};
		else chk_ff <= nxt_chk;
	end

	// ********
	// Properties
	// ********
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	a_oe_in_shift: assert property ($rose(test_data_out_oe) |-> shift)
		else $error("data out enabled outside a shift state");
	a_oe_float_idle: assert property ((fall && !shift) |-> ##[1:5] !test_data_out_oe)
		else $error("data out still driven outside a shift state");
	a_tdo_clk_low: assert property ($changed(test_data_out) |-> !test_clock)
		else $error("data out changed while test clock high");
	a_tms_clk_low: assert property ($changed(test_mode_select) |-> !test_clock)
		else $error("mode select changed while test clock high");
	a_tck_high_phase: assert property ($rose(test_clock) |-> test_clock [*3])
		else $error("test clock high phase too short");
	a_ir_capture_bit: assert property ((ir_sh_rise && chk_ff.first) |->
		test_data_out_line)
		else $error("instruction capture bit is not one");
	a_id_first_bit: assert property ((dr_sh_rise && chk_ff.first && id_sel) |->
		test_data_out_line)
		else $error("identity word lsb is not one");
	a_byp_capture: assert property ((dr_sh_rise && chk_ff.first && byp_sel) |->
		!test_data_out_line)
		else $error("bypass stage did not capture zero");
	a_byp_one_stage: assert property ((dr_sh_rise && !chk_ff.first && byp_sel) |->
		test_data_out_line == chk_ff.tdi_q)
		else $error("bypass path is not one stage");
	a_trst_float: assert property ($fell(test_reset_n) |-> ##[1:4] !test_data_out_oe)
		else $error("data out driven during test reset");

	c_ir_update: cover property (rise && chk_ff.st == bst_pkg::TAP_UPD_IR);
	c_byp_shift: cover property (rise && chk_ff.st == bst_pkg::TAP_SH_DR && chk_ff.ir > 3'h2);
	c_trst: cover property ($fell(test_reset_n));
endmodule

// >>> tb_top.sv
// Self-checking bench joining the tester end to the device end
`timescale 1ns/100ps
`include "bst_defs.svh"
module tb_top;
	typedef struct {
		logic [1:0]   op;
		logic [7:0]   len;
		logic [127:0] dat;
		logic [127:0] exp;
		logic [1:0]   pchk;
		logic [125:0] pv;
	} bst_row_t;
	localparam logic [31:0]  ID_WORD = {4'h1, 16'h0c3a, 11'h07b, 1'h1};
	localparam logic [125:0] PIN_PAT = {14{9'h1a5}};
	localparam logic [125:0] PRE_A   = {14{9'h0f3}};
	localparam logic [125:0] PRE_B   = {14{9'h10c}};
	logic              mclk;
	logic              rst;
	logic              cmd_valid;
	bst_pkg::bst_op_t  cmd_op;
	logic [7:0]        cmd_len;
	logic [127:0]      cmd_data;
	logic              cmd_ready;
	logic              rsp_valid;
	logic [127:0]      rsp_data;
	logic [125:0]      core_out;
	logic [125:0]      core_oe;
	logic [125:0]      pin_in;
	logic [125:0]      pin_out;
	logic [125:0]      pin_oe;
	int                n_fail;
	int                tests_run;
	bst_row_t          rows [16];

	bst_if bst_link ();
	bst_host u_bst_host (.mclk(mclk), .rst(rst), .jtag(bst_link), .cmd_valid(cmd_valid),
		.cmd_op(cmd_op), .cmd_len(cmd_len), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data));
	bst_dev u_bst_dev (.mclk(mclk), .rst(rst), .jtag(bst_link), .core_out(core_out),
		.core_oe(core_oe), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
	bst_asserts u_bst_asserts (.mclk(mclk), .rst(rst), .test_clock(bst_link.test_clock),
		.test_mode_select(bst_link.test_mode_select), .test_data_in(bst_link.test_data_in),
		.test_reset_n(bst_link.test_reset_n), .test_data_out(bst_link.test_data_out),
		.test_data_out_oe(bst_link.test_data_out_oe),
		.test_data_out_line(bst_link.test_data_out_line));

	// ********
	// Tasks
	// ********
	task automatic check(input logic [127:0] seen, input logic [127:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	task automatic run_cmd(input logic [1:0] op, input logic [7:0] len, input logic [127:0] dat);
		int i;
		@(negedge mclk);
		cmd_valid = 1'b1;
		cmd_op = bst_pkg::bst_op_t'(op);
		cmd_len = len;
		cmd_data = dat;
		@(negedge mclk);
		cmd_valid = 1'b0;
		for (i = 0; i < 5000 && rsp_valid !== 1'b1; i++) @(negedge mclk);
		if (i == 5000) begin
			n_fail++;
			$display("[ERR] %0t no response to command", $time);
		end
	endtask

	task automatic pin_chk(input logic [1:0] m, input logic [125:0] v);
		logic [125:0] eo;
		repeat (8) @(negedge mclk);
		eo = '1;
		eo[66] = v[67];
		if (m == 2'h1) begin
			check(128'(pin_out), 128'(core_out));
			check(128'(pin_oe), 128'(core_oe));
		end else if (m == 2'h2) begin
			check(128'(pin_out), 128'(v));
			check(128'(pin_oe), 128'(eo));
		end else begin
			check(128'(pin_oe), 128'h0);
		end
	endtask

	// ********
	// Stimulus
	// ********
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	initial begin
		#600000;
		n_fail++;
		finish_test();
	end

	initial begin
		n_fail = 0;
		tests_run = 0;
		rst = 1'b1;
		cmd_valid = 1'b0;
		cmd_op = bst_pkg::OP_RESET;
		cmd_len = 8'h01;
		cmd_data = '0;
		core_out = {14{9'h155}};
		core_oe = {14{9'h0aa}};
		pin_in = PIN_PAT;
		rows = '{
			'{2'h2, 8'h20, '0, 128'(ID_WORD), 2'h1, '0},
			'{2'h1, 8'h03, 128'h7, 128'h1, 2'h1, '0},
			'{2'h2, 8'h04, 128'hb, 128'h6, 2'h1, '0},
			'{2'h1, 8'h03, 128'h2, 128'h1, 2'h1, '0},
			'{2'h2, 8'h7e, 128'(PRE_A), 128'(PIN_PAT), 2'h1, '0},
			'{2'h1, 8'h03, 128'h0, 128'h1, 2'h2, PRE_A},
			'{2'h2, 8'h7e, 128'(PRE_B), 128'(PIN_PAT), 2'h2, PRE_B},
			'{2'h1, 8'h03, 128'h3, 128'h1, 2'h2, PRE_B},
			'{2'h2, 8'h02, 128'h1, 128'h2, 2'h2, PRE_B},
			'{2'h1, 8'h03, 128'h4, 128'h1, 2'h3, '0},
			'{2'h2, 8'h02, 128'h1, 128'h2, 2'h3, '0},
			'{2'h1, 8'h03, 128'h1, 128'h1, 2'h1, '0},
			'{2'h2, 8'h20, '0, 128'(ID_WORD), 2'h1, '0},
			'{2'h1, 8'h03, 128'h7, 128'h1, 2'h1, '0},
			'{2'h0, 8'h01, '0, '0, 2'h0, '0},
			'{2'h2, 8'h20, '0, 128'(ID_WORD), 2'h1, '0}
		};
		repeat (2) @(negedge mclk);
		rst = 1'b0;
		foreach (rows[r]) begin
			run_cmd(rows[r].op, rows[r].len, rows[r].dat);
			if (rows[r].op != 2'h0)
				check(rsp_data & ~({128{1'b1}} << rows[r].len), rows[r].exp);
			if (rows[r].pchk != 2'h0) pin_chk(rows[r].pchk, rows[r].pv);
			$display("test %0d done", r);
		end
		run_cmd(2'h1, 8'h03, 128'h7);
		@(negedge mclk);
		rst = 1'b1;
		repeat (2) @(negedge mclk);
		check(128'(cmd_ready), 128'h1);
		rst = 1'b0;
		run_cmd(2'h2, 8'h20, '0);
		check(rsp_data & 128'hffffffff, 128'(ID_WORD));
		pin_chk(2'h1, '0);
		$display("test reset done");
		finish_test();
	end
endmodule
